//--- supervisor_defs.svh
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// Clock rate of clk_sys in kHz (100 MHz).
`define SUP_CLK_KHZ 100000
// Least reset stretch time in ms.
`define SUP_STRETCH_MS 140
// Nominal watchdog timeout in ms.
`define SUP_TIMEOUT_MS 1600
// Cycles of the reset stretch, rounded up.
`define SUP_STRETCH_CYC (`SUP_STRETCH_MS * `SUP_CLK_KHZ)
// Cycles of the watchdog timeout, rounded down.
`define SUP_TIMEOUT_CYC (`SUP_TIMEOUT_MS * `SUP_CLK_KHZ)
// Width of the shared timing counters.
`define SUP_CNT_W 28

`endif

//--- supervisor_pkg.sv
package supervisor_pkg;

    // Kick input as two digital indications.
    typedef struct packed {
        logic level;
        logic mid;
    } kick_type;

    // Reset output pair.
    typedef struct packed {
        logic rst_n;
        logic rst;
    } reset_pair_type;

    // Reset stretch state machine.
    typedef enum logic [1:0] {
        ST_SUPPLY_LOW,
        ST_STRETCH,
        ST_RUN
    } sup_state_type;

endpackage : supervisor_pkg

//--- supply_supervisor_watchdog.sv
`timescale 1ns/1ns
`include "supervisor_defs.svh"
module supply_supervisor_watchdog #(
    parameter logic [`SUP_CNT_W-1:0] STRETCH_CYCLES = `SUP_CNT_W'(`SUP_STRETCH_CYC),
    parameter logic [`SUP_CNT_W-1:0] TIMEOUT_CYCLES = `SUP_CNT_W'(`SUP_TIMEOUT_CYC)
) (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // Supply monitor.
    input wire logic supply_low,
    // Three-level kick input as level plus mid flag.
    input wire supervisor_pkg::kick_type watchdog_kick_in,
    // Reset outputs.
    output supervisor_pkg::reset_pair_type sys_reset,
    // Watchdog fault, active low.
    output logic watchdog_fault_out_n
);

    // Synchroniser stages for the kick indications.
    supervisor_pkg::kick_type kick_s1_r;
    supervisor_pkg::kick_type kick_s2_r;
    supervisor_pkg::kick_type kick_s3_r;
    // Stretch state machine and its counter.
    supervisor_pkg::sup_state_type state_r, state_nxt;
    logic [`SUP_CNT_W-1:0] stretch_cnt_r, stretch_cnt_nxt;
    // Watchdog timer.
    logic [`SUP_CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
    // Registered outputs.
    logic rst_n_r, rst_n_nxt;
    logic fault_n_r, fault_n_nxt;
    // Decoded events.
    logic kick_edge;
    logic wd_enabled;
    logic wd_expire;

    // True when a counter sits on the last cycle before its terminal count.
    // Both the stretch and the watchdog timer end this way, so they share it.
    function automatic logic at_last_cycle(input logic [`SUP_CNT_W-1:0] cnt, input logic [`SUP_CNT_W-1:0] limit);
        at_last_cycle = (cnt == limit - `SUP_CNT_W'(1));
    endfunction : at_last_cycle

    // Synchronise both kick indications; stage one feeds only stage two.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            kick_s1_r <= '0;
            kick_s2_r <= '0;
            kick_s3_r <= '0;
        end else if (clk_en) begin
            kick_s1_r <= watchdog_kick_in;
            kick_s2_r <= kick_s1_r;
            kick_s3_r <= kick_s2_r;
        end
    end

    // A service edge is any level change while the input is driven.
    always_comb begin
        wd_enabled = !kick_s2_r.mid && !kick_s3_r.mid;
        kick_edge = wd_enabled && (kick_s2_r.level != kick_s3_r.level);
        wd_expire = wd_enabled && (state_r == supervisor_pkg::ST_RUN)
            && at_last_cycle(wd_cnt_r, TIMEOUT_CYCLES);
    end

    // Next-state logic for the reset stretch and the watchdog timer.
    always_comb begin
        state_nxt = state_r;
        stretch_cnt_nxt = stretch_cnt_r;
        wd_cnt_nxt = wd_cnt_r;
        fault_n_nxt = fault_n_r;
        case (state_r)
            supervisor_pkg::ST_SUPPLY_LOW: begin
                // Hold reset while the supply is low.
                stretch_cnt_nxt = '0;
                wd_cnt_nxt = '0;
                if (!supply_low) begin
                    state_nxt = supervisor_pkg::ST_STRETCH;
                end
            end
            supervisor_pkg::ST_STRETCH: begin
                // Count out the minimum reset time.
                wd_cnt_nxt = '0;
                if (at_last_cycle(stretch_cnt_r, STRETCH_CYCLES)) begin
                    state_nxt = supervisor_pkg::ST_RUN;
                    stretch_cnt_nxt = '0;
                end else begin
                    stretch_cnt_nxt = stretch_cnt_r + `SUP_CNT_W'(1);
                end
            end
            supervisor_pkg::ST_RUN: begin
                // Watchdog runs only while reset is released.
                if (!wd_enabled || kick_edge) begin
                    wd_cnt_nxt = '0;
                end else if (wd_expire) begin
                    wd_cnt_nxt = '0;
                    state_nxt = supervisor_pkg::ST_STRETCH;
                end else begin
                    wd_cnt_nxt = wd_cnt_r + `SUP_CNT_W'(1);
                end
            end
            default: begin
                state_nxt = supervisor_pkg::ST_SUPPLY_LOW;
            end
        endcase
        // Fault flag: the timeout pulls it low, service or disable release it.
        if (wd_expire && !kick_edge) begin
            fault_n_nxt = 1'b0;
        end
        if (kick_edge || !wd_enabled) begin
            fault_n_nxt = 1'b1;
        end
        // Supply low overrides everything.
        if (supply_low) begin
            state_nxt = supervisor_pkg::ST_SUPPLY_LOW;
            stretch_cnt_nxt = '0;
            wd_cnt_nxt = '0;
            fault_n_nxt = 1'b1;
        end
        rst_n_nxt = (state_nxt == supervisor_pkg::ST_RUN);
    end

    // Register state and outputs.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= supervisor_pkg::ST_SUPPLY_LOW;
            stretch_cnt_r <= '0;
            wd_cnt_r <= '0;
            rst_n_r <= 1'b0;
            fault_n_r <= 1'b1;
        end else if (clk_en) begin
            state_r <= state_nxt;
            stretch_cnt_r <= stretch_cnt_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            rst_n_r <= rst_n_nxt;
            fault_n_r <= fault_n_nxt;
        end
    end

    // Both reset polarities from one flip-flop pair kept in step.
    logic rst_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_r <= 1'b1;
        end else if (clk_en) begin
            rst_r <= !rst_n_nxt;
        end
    end

    always_comb begin
        sys_reset.rst_n = rst_n_r;
        sys_reset.rst = rst_r;
        watchdog_fault_out_n = fault_n_r;
    end

    // Reset is low whenever the supply was low on the previous edge.
    a_supply_low_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && supply_low |=> !sys_reset.rst_n)
        else $error("reset not asserted while supply low");

    // Complement outputs always differ.
    a_reset_complement: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sys_reset.rst == !sys_reset.rst_n)
        else $error("reset outputs not complementary");

    // Supply low forces the fault output high.
    a_supply_fault_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && supply_low |=> watchdog_fault_out_n)
        else $error("fault output low during supply low");

    // Disabled watchdog keeps the fault output high.
    a_disabled_fault_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !wd_enabled |=> watchdog_fault_out_n)
        else $error("fault output low while watchdog disabled");

    // Disabled watchdog never starts a reset.
    a_disabled_no_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !wd_enabled && !supply_low && sys_reset.rst_n |=> sys_reset.rst_n)
        else $error("reset while watchdog disabled");

    // A service edge clears the timer.
    a_kick_clears_timer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && kick_edge && !supply_low |=> wd_cnt_r == '0)
        else $error("timer not cleared by service edge");

    // Expiry pulls reset and fault low together.
    sequence expire_seq;
        clk_en && wd_expire && !kick_edge && !supply_low;
    endsequence
    a_expire_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        expire_seq |=> !sys_reset.rst_n && !watchdog_fault_out_n)
        else $error("timeout did not assert reset and fault");

    // Reset is released only after a full stretch count.
    a_release_after_stretch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(sys_reset.rst_n) |-> $past(stretch_cnt_r) == STRETCH_CYCLES - `SUP_CNT_W'(1))
        else $error("reset released before stretch ended");

    // Fault stays low until a service edge, disable or supply low.
    a_fault_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !watchdog_fault_out_n && clk_en && !kick_edge && wd_enabled && !supply_low
        |=> !watchdog_fault_out_n)
        else $error("fault output released without service");

    // Helper for the stretch checks: enabled cycles for which reset has stood low.
    logic [`SUP_CNT_W-1:0] low_run_r, low_run_nxt;

    // Count low cycles, clear while released, and saturate so a long supply dip cannot wrap.
    always_comb begin
        low_run_nxt = low_run_r;
        if (sys_reset.rst_n) begin
            // Released: the next low stretch counts from zero.
            low_run_nxt = '0;
        end else if (low_run_r != '1) begin
            // Held low: one more enabled cycle.
            low_run_nxt = low_run_r + `SUP_CNT_W'(1);
        end
    end

    // Register the helper count on enabled edges only, like the logic it watches.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            low_run_r <= '0;
        end else if (clk_en) begin
            low_run_r <= low_run_nxt;
        end
    end

    // Reset is never released before a full stretch of low cycles.
    a_stretch_min_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(sys_reset.rst_n) |-> low_run_r >= STRETCH_CYCLES)
        else $error("reset low for fewer cycles than the stretch");

    // A low clock enable freezes the outputs and the state.
    a_freeze_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clk_en |=> $stable(sys_reset) && $stable(watchdog_fault_out_n) && $stable(state_r))
        else $error("state moved while the clock enable was low");

    // A service edge always returns the fault output high.
    a_kick_releases_fault: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && kick_edge |=> watchdog_fault_out_n)
        else $error("fault output not released by service edge");

    // A mid-level kick keeps the timer parked at zero.
    a_mid_clears_timer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !wd_enabled |=> wd_cnt_r == '0)
        else $error("timer ran while watchdog disabled");

    // One quiet enabled cycle in the run state: the timer must step by one.
    sequence run_idle_seq;
        clk_en && (state_r == supervisor_pkg::ST_RUN) && wd_enabled && !kick_edge && !wd_expire && !supply_low;
    endsequence
    a_timer_advances: assert property (@(posedge clk_sys) disable iff (!reset_n)
        run_idle_seq |=> wd_cnt_r == $past(wd_cnt_r) + `SUP_CNT_W'(1))
        else $error("watchdog timer did not advance");

    // One enabled cycle of the stretch short of its end: the stretch counter steps.
    sequence stretch_step_seq;
        clk_en && (state_r == supervisor_pkg::ST_STRETCH) && !supply_low
            && !at_last_cycle(stretch_cnt_r, STRETCH_CYCLES);
    endsequence
    a_stretch_advances: assert property (@(posedge clk_sys) disable iff (!reset_n)
        stretch_step_seq |=> stretch_cnt_r == $past(stretch_cnt_r) + `SUP_CNT_W'(1))
        else $error("stretch counter did not advance");

    // After an expiry a fresh stretch starts, so static kicks repeat the pulse.
    a_expire_restretch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        expire_seq |=> state_r == supervisor_pkg::ST_STRETCH && stretch_cnt_r == '0)
        else $error("expiry did not restart the stretch");

    // The timer never passes its terminal count.
    a_timer_bounded: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wd_cnt_r < TIMEOUT_CYCLES)
        else $error("watchdog timer beyond its terminal count");

    // A supply dip always sends the machine back to the low state.
    a_supply_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && supply_low |=> state_r == supervisor_pkg::ST_SUPPLY_LOW)
        else $error("supply low did not reach the low state");

    // A released reset only ever stands in the run state.
    a_release_in_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
        sys_reset.rst_n |-> state_r == supervisor_pkg::ST_RUN)
        else $error("reset released outside the run state");

endmodule : supply_supervisor_watchdog

//--- kick_driver_model.sv
`timescale 1ns/1ns
// Processor side of the kick line: it toggles, holds still or floats.
module kick_driver_model (
    // Clock.
    input wire logic clk_sys,
    // Behaviour: 0 toggles, 1 holds still, 2 floats.
    input wire logic [1:0] mode,
    // Kick line as the supervisor sees it.
    output supervisor_pkg::kick_type kick
);
    int unsigned gap = 0; // Cycles left until the next toggle.
    initial kick = '{level: 1'b0, mid: 1'b0};
    // Changes land on the falling edge, away from the sampling edge.
    always @(negedge clk_sys) begin
        if (mode == 2'h2) begin
            // A floating line reads mid-level and its logic level is junk.
            kick.mid <= 1'b1;
            kick.level <= ~kick.level;
        end else begin
            kick.mid <= 1'b0;
            if (mode == 2'h0 && gap == 0) begin
                // Toggle at a random spacing well inside the timeout.
                kick.level <= ~kick.level;
                gap <= 4 + ($urandom % 30);
            end else if (gap != 0) begin
                gap <= gap - 1;
            end
        end
    end
endmodule : kick_driver_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
    localparam int STRETCH = 20; // Shortened reset stretch.
    localparam int TIMEOUT = 50; // Shortened watchdog timeout.
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic supply_low = 1'b0;
    logic clk_en = 1'b1;
    int k;
    logic [1:0] mode = 2'h1;
    supervisor_pkg::kick_type kick;
    supervisor_pkg::reset_pair_type sys_reset;
    logic watchdog_fault_out_n;
    int fail_count = 0;
    int checked = 0;
    int lows;
    int n;
    always #5 clk_sys = ~clk_sys;
    kick_driver_model u_kick (.clk_sys(clk_sys), .mode(mode), .kick(kick));
    supply_supervisor_watchdog #(.STRETCH_CYCLES(28'(STRETCH)), .TIMEOUT_CYCLES(28'(TIMEOUT))) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .supply_low(supply_low),
        .watchdog_kick_in(kick), .sys_reset(sys_reset), .watchdog_fault_out_n(watchdog_fault_out_n));
    // Compares one value and reports a mismatch.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Lets k cycles pass, counting cycles with reset low and checking the complement.
    task automatic run(input int k);
        lows = 0;
        repeat (k) begin
            @(negedge clk_sys);
            if (sys_reset.rst_n === 1'b0) lows++;
            chk("rst", 16'(sys_reset.rst), 16'(!sys_reset.rst_n));
        end
    endtask : run
    // Waits out a low reset, then counts cycles until it falls again.
    task automatic wait_fall();
        n = 0;
        while (sys_reset.rst_n !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        n = 0;
        while (sys_reset.rst_n !== 1'b0 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wait_fall
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Watchdog against a hung run.
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'hbbe7));
        repeat (4) @(negedge clk_sys);
        chk("fault_in_reset", 16'(watchdog_fault_out_n), 16'h1);
        reset_n = 1'b1;
        run(STRETCH);
        chk("powerup_low", 16'(lows), 16'(STRETCH));
        run(3);
        chk("powerup_release", 16'(lows), 16'h0);
        mode = 2'h0;
        run(400);
        chk("kicked_lows", 16'(lows), 16'h0);
        chk("kicked_fault", 16'(watchdog_fault_out_n), 16'h1);
        mode = 2'h1;
        wait_fall();
        chk("expiry_bound", 16'(n <= TIMEOUT + 6), 16'h1);
        chk("expiry_fault", 16'(watchdog_fault_out_n), 16'h0);
        // Freeze the block for a random span; the stretch must not advance.
        k = 1 + ($urandom % 8);
        clk_en = 1'b0;
        run(k);
        chk("freeze_rst", 16'(lows), 16'(k));
        chk("freeze_fault", 16'(watchdog_fault_out_n), 16'h0);
        clk_en = 1'b1;
        // One low cycle was already seen when the fall was found.
        run(STRETCH);
        chk("expiry_low", 16'(lows), 16'(STRETCH - 1));
        wait_fall();
        chk("repeat_gap", 16'(n >= TIMEOUT - 2 && n <= TIMEOUT + 3), 16'h1);
        chk("fault_held", 16'(watchdog_fault_out_n), 16'h0);
        mode = 2'h0;
        run(6);
        chk("fault_cleared", 16'(watchdog_fault_out_n), 16'h1);
        mode = 2'h2;
        run(STRETCH + 5);
        run(3 * TIMEOUT);
        chk("float_lows", 16'(lows), 16'h0);
        chk("float_fault", 16'(watchdog_fault_out_n), 16'h1);
        mode = 2'h1;
        wait_fall();
        supply_low = 1'b1;
        run(2);
        chk("supply_rst", 16'(sys_reset.rst_n), 16'h0);
        chk("supply_fault", 16'(watchdog_fault_out_n), 16'h1);
        n = 2 + ($urandom % 20);
        run(n);
        chk("supply_hold", 16'(lows), 16'(n));
        supply_low = 1'b0;
        run(STRETCH);
        chk("recover_low", 16'(lows), 16'(STRETCH));
        stop_test();
    end
endmodule : tb_top
